/* File: src/fpe_ctrl.sv */
// Flash program and erase sequencer with Avalon-MM register slave
//
// How it works
// - Sector bit 7 selects information page
// - Low seven bits pick main page
// - Small variant keeps only six page bits
// - Three-bit row addresses every I/O write
// - Info page limits row to 0-1
// - Seven-bit column addresses I/O writes
// - Row program increments column from start
// - Full erase clears everything, about 200ms
// - Page erase clears 1KB, about 10ms
// - Erase bits clear themselves when done
// - Flash accesses wait during any erase
// - Non-flash accesses never wait
// - Flash reads wait during row program
// - Row bit clears at 128 or timeout
// - Bit 1 page erase, bit 0 full
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "fpe_map.svh"

module fpe_ctrl
   import fpe_pkg::*;
#(
   parameter int unsigned PAGE_BITS = 7,
   parameter int unsigned MASS_CYC =
      `FPE_MASS_MS * `FPE_CLK_KHZ,
   parameter int unsigned PAGE_CYC =
      `FPE_PAGE_MS * `FPE_CLK_KHZ,
   parameter int unsigned ROW_TMO_CYC =
      `FPE_ROW_TMO_MS * `FPE_CLK_KHZ
) (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic FL_RD,
   input wire logic FL_WR,
   output logic FL_WAIT,
   input wire logic FL_IO_WR,
   input wire logic [7:0] FL_IO_DATA,
   output logic FL_PROG_STB,
   output logic [7:0] FL_PROG_DATA,
   output fpe_addr_t FL_PROG_ADDR,
   output logic FL_ERASE_MASS,
   output logic FL_ERASE_PAGE,
   output logic FL_ROW_ACTIVE,
   output logic IRQ
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] idx);
      hit = (a == idx);
   endfunction : hit

   localparam logic [6:0] PAGE_MASK =
      7'((8'h01 << PAGE_BITS) - 8'h01);

   fpe_regs_t s_reg;
   fpe_regs_t s_next;
   logic req;
   logic take;
   logic wr_take;
   logic be0;
   logic [7:0] wd;
   logic [3:0] ev_set;
   logic [3:0] ev_clr;
   logic [2:0] row_eff;
   logic [6:0] page_eff;
   logic busy_erase;
   logic [7:0] rd_val;

   assign req = AVS_READ | AVS_WRITE;
   assign take = req & s_reg.ack;
   assign wr_take = take & AVS_WRITE;
   assign be0 = AVS_BYTEENABLE[0];
   assign wd = AVS_WRITEDATA[7:0];
   assign busy_erase = (s_reg.st == FPE_MASS) |
                       (s_reg.st == FPE_PAGE);

   // ----------------------------------------
   // Effective flash address
   // ----------------------------------------
   always_comb begin
      page_eff = s_reg.sect[6:0] & PAGE_MASK;
      row_eff = s_reg.row;
      if (s_reg.sect[`FPE_SECT_INFO]) begin
         page_eff = 7'h00;
         row_eff = s_reg.row & `FPE_ROW_INFO_MASK;
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always_comb begin
      rd_val = 8'h00;
      case (1'b1)
         hit(AVS_ADDRESS, `FPE_IDX_SECT): begin
            rd_val = {s_reg.sect[7], s_reg.sect[6:0] & PAGE_MASK};
         end
         hit(AVS_ADDRESS, `FPE_IDX_ROW): begin
            rd_val = {5'h00, s_reg.row};
         end
         hit(AVS_ADDRESS, `FPE_IDX_COL): begin
            rd_val = {1'b0, s_reg.col};
         end
         hit(AVS_ADDRESS, `FPE_IDX_CTL): begin
            rd_val = {5'h00, s_reg.st == FPE_ROW,
                      s_reg.st == FPE_PAGE,
                      s_reg.st == FPE_MASS};
         end
         hit(AVS_ADDRESS, `FPE_IDX_EVT): begin
            rd_val = {4'h0, s_reg.evt};
         end
         hit(AVS_ADDRESS, `FPE_IDX_MASK): begin
            rd_val = {4'h0, s_reg.mask};
         end
         default: begin
            rd_val = 8'h00;
         end
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      ev_set = 4'h0;
      ev_clr = 4'h0;
      s_next.prog_stb = 1'b0;
      // Answer one cycle after the request appears
      s_next.ack = req & ~s_reg.ack;
      if (req & ~s_reg.ack) begin
         s_next.rdata = rd_val;
      end

      // Register writes
      if (wr_take & be0) begin
         if (hit(AVS_ADDRESS, `FPE_IDX_SECT)) begin
            s_next.sect = {wd[7], wd[6:0] & PAGE_MASK};
         end
         if (hit(AVS_ADDRESS, `FPE_IDX_ROW)) begin
            s_next.row = wd[2:0];
         end
         if (hit(AVS_ADDRESS, `FPE_IDX_COL)) begin
            s_next.col = wd[6:0];
         end
         if (hit(AVS_ADDRESS, `FPE_IDX_MASK)) begin
            s_next.mask = wd[3:0];
         end
      end
      // Reading the event register clears what it showed
      if (take & AVS_READ & hit(AVS_ADDRESS, `FPE_IDX_EVT)) begin
         ev_clr = s_reg.rdata[3:0];
      end

      // Sequencer; a running operation cannot be aborted
      case (s_reg.st)
         FPE_IDLE: begin
            s_next.cnt = 32'h0;
            if (wr_take & be0 & hit(AVS_ADDRESS, `FPE_IDX_CTL)) begin
               if (wd[`FPE_CTL_MASS]) begin
                  s_next.st = FPE_MASS;
               end else if (wd[`FPE_CTL_PAGE]) begin
                  s_next.st = FPE_PAGE;
               end else if (wd[`FPE_CTL_ROW]) begin
                  s_next.st = FPE_ROW;
                  s_next.inc = {1'b0, s_reg.col};
               end
            end else if (FL_IO_WR) begin
               // Single byte at the chosen column
               s_next.prog_stb = 1'b1;
               s_next.prog_data = FL_IO_DATA;
               s_next.prog_addr = '{info: s_reg.sect[7],
                  page: page_eff, row: row_eff,
                  col: s_reg.col};
            end
         end
         FPE_MASS: begin
            s_next.cnt = s_reg.cnt + 32'h1;
            if (s_reg.cnt >= MASS_CYC - 1) begin
               s_next.st = FPE_IDLE;
               ev_set[`FPE_EVT_MASS] = 1'b1;
            end
         end
         FPE_PAGE: begin
            s_next.cnt = s_reg.cnt + 32'h1;
            if (s_reg.cnt >= PAGE_CYC - 1) begin
               s_next.st = FPE_IDLE;
               ev_set[`FPE_EVT_PAGE] = 1'b1;
            end
         end
         FPE_ROW: begin
            s_next.cnt = s_reg.cnt + 32'h1;
            if (FL_IO_WR) begin
               // Timeout restarts with every byte
               s_next.cnt = 32'h0;
               s_next.prog_stb = 1'b1;
               s_next.prog_data = FL_IO_DATA;
               s_next.prog_addr = '{info: s_reg.sect[7],
                  page: page_eff, row: row_eff,
                  col: s_reg.inc[6:0]};
               s_next.inc = s_reg.inc + 8'h01;
               if (s_reg.inc + 8'h01 == `FPE_COL_END) begin
                  s_next.st = FPE_IDLE;
                  ev_set[`FPE_EVT_ROW] = 1'b1;
               end
            end else if (s_reg.cnt >= ROW_TMO_CYC - 1) begin
               s_next.st = FPE_IDLE;
               ev_set[`FPE_EVT_TMO] = 1'b1;
            end
         end
         default: begin
            s_next.st = FPE_IDLE;
         end
      endcase

      // Set wins over a clear in the same cycle
      s_next.evt = (s_reg.evt & ~ev_clr) | ev_set;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SRST) begin
         s_reg <= '{st: FPE_IDLE, cnt: 32'h0,
            sect: `FPE_SECT_RST, row: `FPE_ROW_RST,
            col: `FPE_COL_RST, inc: 8'h00,
            evt: `FPE_EVT_RST, mask: `FPE_MASK_RST,
            ack: 1'b0, rdata: 8'h00, prog_stb: 1'b0,
            prog_data: 8'h00, prog_addr: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign AVS_WAITREQUEST = req & ~s_reg.ack;
   assign AVS_READDATA = {24'h0, s_reg.rdata};
   // Only flash cycles stall; other targets never see this
   assign FL_WAIT = (busy_erase & (FL_RD | FL_WR))
      | ((s_reg.st == FPE_ROW) & FL_RD);
   assign FL_PROG_STB = s_reg.prog_stb;
   assign FL_PROG_DATA = s_reg.prog_data;
   assign FL_PROG_ADDR = s_reg.prog_addr;
   assign FL_ERASE_MASS = s_reg.st == FPE_MASS;
   // Page erase output is the state alone; the info select does not reach it
   assign FL_ERASE_PAGE = s_reg.st == FPE_PAGE;
   assign FL_ROW_ACTIVE = s_reg.st == FPE_ROW;
   assign IRQ = |(s_reg.evt & s_reg.mask);

endmodule : fpe_ctrl
`default_nettype wire

/* File: src/fpe_map.svh */
// Register map, field positions, reset values and timing figures
`ifndef FPE_MAP_SVH
`define FPE_MAP_SVH

// ----------------------------------------
// Register indices (byte address = 4*index)
// ----------------------------------------
`define FPE_IDX_SECT 8'hfc
`define FPE_IDX_ROW 8'hfd
`define FPE_IDX_COL 8'hfe
`define FPE_IDX_CTL 8'hff
`define FPE_IDX_EVT 8'hf8
`define FPE_IDX_MASK 8'hf9

// ----------------------------------------
// Fields
// ----------------------------------------
`define FPE_SECT_INFO 7
`define FPE_CTL_ROW 2
`define FPE_CTL_PAGE 1
`define FPE_CTL_MASS 0
`define FPE_EVT_MASS 0
`define FPE_EVT_PAGE 1
`define FPE_EVT_ROW 2
`define FPE_EVT_TMO 3
`define FPE_ROW_INFO_MASK 3'h1
`define FPE_COL_END 8'h80

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FPE_SECT_RST 8'h00
`define FPE_ROW_RST 3'h0
`define FPE_COL_RST 7'h00
`define FPE_EVT_RST 4'h0
`define FPE_MASK_RST 4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define FPE_CLK_KHZ 200000
`define FPE_MASS_MS 200
`define FPE_PAGE_MS 10
`define FPE_ROW_TMO_MS 1

`endif

/* File: src/fpe_pkg.sv */
// Types shared by the flash program and erase sequencer
package fpe_pkg;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [3:0] {
      FPE_IDLE = 4'b0001,
      FPE_MASS = 4'b0010,
      FPE_PAGE = 4'b0100,
      FPE_ROW = 4'b1000
   } fpe_state_t;

   // Flash target address handed to the array
   typedef struct packed {
      logic info;
      logic [6:0] page;
      logic [2:0] row;
      logic [6:0] col;
   } fpe_addr_t;

   // Whole module state
   typedef struct packed {
      fpe_state_t st;
      logic [31:0] cnt;
      logic [7:0] sect;
      logic [2:0] row;
      logic [6:0] col;
      logic [7:0] inc;
      logic [3:0] evt;
      logic [3:0] mask;
      logic ack;
      logic [7:0] rdata;
      logic prog_stb;
      logic [7:0] prog_data;
      fpe_addr_t prog_addr;
   } fpe_regs_t;

endpackage : fpe_pkg

/* File: test/fpe_cpu_model.sv */
// CPU side of the flash port: access levels and I/O byte writes
`timescale 1ns/100ps
`default_nettype none
module fpe_cpu_model (
   input wire logic CLK,
   output logic FL_RD,
   output logic FL_WR,
   output logic FL_IO_WR,
   output logic [7:0] FL_IO_DATA
);
   initial begin
      FL_RD = 1'b0;
      FL_WR = 1'b0;
      FL_IO_WR = 1'b0;
      FL_IO_DATA = 8'h00;
   end
   task acc(input logic r, input logic w);
      @(posedge CLK);
      FL_RD <= r;
      FL_WR <= w;
   endtask : acc
   // Data is not held after the write, so show its inverse
   task io_wr(input logic [7:0] d);
      @(posedge CLK);
      FL_IO_WR <= 1'b1;
      FL_IO_DATA <= d;
      @(posedge CLK);
      FL_IO_WR <= 1'b0;
      FL_IO_DATA <= ~d;
   endtask : io_wr
endmodule : fpe_cpu_model
`default_nettype wire

/* File: test/fpe_ctrl_assertions.sv */
// Port checks for the flash program and erase sequencer
`timescale 1ns/100ps
`default_nettype none
module fpe_ctrl_assertions
   import fpe_pkg::*;
#(parameter int unsigned PAGE_CYC = 10) (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic AVS_WAITREQUEST,
   input wire logic FL_RD,
   input wire logic FL_WR,
   input wire logic FL_WAIT,
   input wire logic FL_IO_WR,
   input wire logic FL_PROG_STB,
   input wire fpe_addr_t FL_PROG_ADDR,
   input wire logic FL_ERASE_MASS,
   input wire logic FL_ERASE_PAGE,
   input wire logic FL_ROW_ACTIVE
);
   localparam int PL = PAGE_CYC - 1;
   localparam int PH = PAGE_CYC + 1;
   logic seen;
   logic [6:0] last_col;
   wire logic busy = FL_ERASE_MASS | FL_ERASE_PAGE;
   // Tracks the previous byte of the same row burst only
   always_ff @(posedge CLK) begin
      if (SRST || !FL_ROW_ACTIVE) begin
         seen <= 1'b0;
      end else if (FL_PROG_STB) begin
         seen <= 1'b1;
         last_col <= FL_PROG_ADDR.col;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   sequence s_hshake;
      AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
   endsequence
   a_bus_one_wait: assert property ($rose(AVS_READ | AVS_WRITE) |-> s_hshake)
      else $error("bus wait count wrong");
   a_erase_stall: assert property (busy && (FL_RD || FL_WR) |-> FL_WAIT)
      else $error("flash access not stalled in erase");
   a_row_stall: assert property (FL_ROW_ACTIVE && FL_RD |-> FL_WAIT)
      else $error("flash read not stalled in row program");
   a_idle_free: assert property (!busy && !FL_ROW_ACTIVE |-> !FL_WAIT)
      else $error("stall while idle");
   a_erase_refuse: assert property (busy && FL_IO_WR |=> !FL_PROG_STB)
      else $error("byte written during erase");
   a_row_strobe: assert property (FL_ROW_ACTIVE && FL_IO_WR |=> FL_PROG_STB)
      else $error("row byte not strobed");
   a_col_step: assert property (FL_PROG_STB && seen |->
      FL_PROG_ADDR.col == last_col + 7'h01) else $error("column not stepped");
   a_page_end: assert property ($rose(FL_ERASE_PAGE) |->
      ##[PL:PH] !FL_ERASE_PAGE) else $error("page erase length wrong");
endmodule : fpe_ctrl_assertions
bind fpe_ctrl fpe_ctrl_assertions #(.PAGE_CYC(PAGE_CYC)) i_fpe_ctrl_assertions (
   .CLK, .SRST, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .FL_RD, .FL_WR,
   .FL_WAIT, .FL_IO_WR, .FL_PROG_STB, .FL_PROG_ADDR, .FL_ERASE_MASS,
   .FL_ERASE_PAGE, .FL_ROW_ACTIVE);
`default_nettype wire

/* File: test/fpe_ctrl_test.sv */
// Self-checking bench for the flash program and erase sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) num_checks++; \
   if ((a) !== (e)) begin \
      err_total++; \
      $display("unexpected %s exp %h got %h", n, e, a); \
   end
module fpe_ctrl_test
   import fpe_pkg::*;
;
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic [7:0] AVS_ADDRESS = 8'h00;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [3:0] AVS_BYTEENABLE = 4'h1;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST, FL_RD, FL_WR, FL_WAIT, FL_IO_WR, FL_PROG_STB;
   logic FL_ERASE_MASS, FL_ERASE_PAGE, FL_ROW_ACTIVE, IRQ;
   logic [7:0] FL_IO_DATA, FL_PROG_DATA, q;
   fpe_addr_t FL_PROG_ADDR;
   logic [7:0] rst_a [7] = '{8'hfc, 8'hfd, 8'hfe, 8'hff, 8'hf8, 8'hf9, 8'h10};
   int err_total = 0;
   int num_checks = 0;
   always #2.5 CLK = ~CLK;
   // Small counts keep the erase and timeout runs short
   fpe_ctrl #(.MASS_CYC(20), .PAGE_CYC(10), .ROW_TMO_CYC(16)) i_fpe_ctrl (
      .CLK, .SRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_BYTEENABLE,
      .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .FL_RD, .FL_WR,
      .FL_WAIT, .FL_IO_WR, .FL_IO_DATA, .FL_PROG_STB, .FL_PROG_DATA,
      .FL_PROG_ADDR, .FL_ERASE_MASS, .FL_ERASE_PAGE, .FL_ROW_ACTIVE, .IRQ);
   fpe_cpu_model i_fpe_cpu_model (.CLK, .FL_RD, .FL_WR, .FL_IO_WR, .FL_IO_DATA);
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= {24'h0, d};
      AVS_WRITE <= w;
      AVS_READ <= ~w;
      @(posedge CLK);
      while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK);
      q = AVS_READDATA[7:0];
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask : bus
   task rchk(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      `CHK("reg", e, q)
   endtask : rchk
   task poll(input logic [7:0] m);
      int n;
      n = 0;
      do begin
         bus(1'b0, 8'hff, 8'h00);
         n++;
      end while ((q & m) != 8'h00 && n < 100);
      `CHK("busy", 8'h00, q & m)
   endtask : poll
   task final_report;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge CLK);
      err_total++;
      final_report();
   end
   initial begin
      repeat (8) @(posedge CLK);
      SRST <= 1'b0;
      foreach (rst_a[i]) rchk(rst_a[i], 8'h00);
      bus(1'b1, 8'hfc, 8'h85);
      rchk(8'hfc, 8'h85);
      AVS_BYTEENABLE <= 4'he;
      bus(1'b1, 8'hfc, 8'h12);
      AVS_BYTEENABLE <= 4'h1;
      rchk(8'hfc, 8'h85);
      bus(1'b1, 8'hfd, 8'hff);
      rchk(8'hfd, 8'h07);
      bus(1'b1, 8'hfe, 8'hff);
      rchk(8'hfe, 8'h7f);
      bus(1'b1, 8'h10, 8'h55);
      rchk(8'h10, 8'h00);
      $display("register test done");
      bus(1'b1, 8'hf9, 8'h02);
      bus(1'b1, 8'hfc, 8'h05);
      i_fpe_cpu_model.acc(1'b1, 1'b0);
      bus(1'b1, 8'hff, 8'h02);
      #1 `CHK("pg", 1'b1, FL_ERASE_PAGE)
      rchk(8'hff, 8'h02);
      #1 `CHK("wait", 1'b1, FL_WAIT)
      poll(8'h02);
      #1 `CHK("irq", 1'b1, IRQ)
      rchk(8'hf8, 8'h02);
      @(posedge CLK);
      #1 `CHK("irq", 1'b0, IRQ)
      $display("page erase test done");
      bus(1'b1, 8'hfc, 8'h80);
      i_fpe_cpu_model.acc(1'b0, 1'b1);
      bus(1'b1, 8'hff, 8'h01);
      #1 `CHK("mass", 1'b1, FL_ERASE_MASS)
      i_fpe_cpu_model.io_wr(8'h3c);
      #1 `CHK("stb", 1'b0, FL_PROG_STB)
      `CHK("wait", 1'b1, FL_WAIT)
      poll(8'h01);
      i_fpe_cpu_model.acc(1'b1, 1'b0);
      rchk(8'hf8, 8'h01);
      $display("mass erase test done");
      bus(1'b1, 8'hfc, 8'h03);
      bus(1'b1, 8'hfd, 8'h05);
      bus(1'b1, 8'hfe, 8'h7e);
      bus(1'b1, 8'hff, 8'h04);
      #1 `CHK("row", 1'b1, FL_ROW_ACTIVE)
      i_fpe_cpu_model.io_wr(8'ha5);
      #1 `CHK("adr", {1'b0, 7'h03, 3'h5, 7'h7e}, FL_PROG_ADDR)
      `CHK("stb", 1'b1, FL_PROG_STB)
      `CHK("wait", 1'b1, FL_WAIT)
      i_fpe_cpu_model.io_wr(8'h5a);
      #1 `CHK("adr", {1'b0, 7'h03, 3'h5, 7'h7f}, FL_PROG_ADDR)
      `CHK("dat", 8'h5a, FL_PROG_DATA)
      rchk(8'hff, 8'h00);
      rchk(8'hf8, 8'h04);
      $display("row program test done");
      bus(1'b1, 8'hfc, 8'h85);
      bus(1'b1, 8'hfd, 8'h03);
      bus(1'b1, 8'hfe, 8'h00);
      bus(1'b1, 8'hff, 8'h04);
      i_fpe_cpu_model.io_wr(8'h11);
      #1 `CHK("adr", {1'b1, 7'h00, 3'h1, 7'h00}, FL_PROG_ADDR)
      poll(8'h04);
      rchk(8'hf8, 8'h08);
      $display("row timeout test done");
      final_report();
   end
endmodule : fpe_ctrl_test
`default_nettype wire
